// [shared/ccdhb_defines.svh]
// Contract
// R01 - Clamp or preblank is suppressed on lines between a mask start and end line.
// R02 - Three mask areas each for clamp and preblank; any hit masks that pulse.
// R03 - Mask areas are global and apply whatever sequence is running.
// R04 - A mask start of 0x1FFF or beyond the sync line count disables that area.
// R05 - Software writes mask start 8191 and end 0 at power-up.
// R06 - Clamp and preblank begin each line at a per-sequence start polarity.
// R07 - Clamp and preblank invert at two per-sequence 13-bit pixel positions.
// R08 - Blanking has no start polarity; its toggles alone mark its intervals.
// R09 - During blanking phase one and copies go low if first mask bit high.
// R10 - Each sequence owns a set of blanking registers; the active one is used.
// R11 - Normal mode toggles blanking at up to six positions per line.
// R12 - Even and odd lines use separate six-position toggle sets.
// R13 - Two-bit mode: 0 normal, 1 pixel mixing, 2 advanced, 3 test.
// R14 - Pixel mixing uses toggles plus start, end, length and repeat settings.
// R15 - Advanced mode places repeat pulses between blanking start and end.
// R16 - Software never writes blanking mode 3.
// R17 - Blanking start and end are 13-bit pixel locations.
// R18 - Blanking length and repeat count are 13-bit values 0 to 8191.
// R19 - Clamp and preblank are active low; software picks values accordingly.
// R20 - Second mask bit sets phase two level, third the last-stage level.
// R21 - A line is masked when start <= line <= end; start > end masks nothing.
`ifndef CCDHB_DEFINES_SVH
`define CCDHB_DEFINES_SVH

// Global area (byte offsets)
`define CCDHB_CLAMP_AREA0 12'h000
`define CCDHB_PREBLANK_PULSE_AREA0 12'h00C
`define CCDHB_STATUS 12'h018
// Per-sequence blocks: base + seq * stride, word index inside
`define CCDHB_SEQ_BASE_BIT 11
`define CCDHB_SEQ_WORDS 17
`define CCDHB_W_CTRL 5'h00
`define CCDHB_W_CLAMP_TOG 5'h01
`define CCDHB_W_PREBLANK_PULSE_TOG 5'h02
`define CCDHB_W_BLANK_SE 5'h03
`define CCDHB_W_BLANK_LR 5'h04
`define CCDHB_W_TOG_EVEN 5'h05
`define CCDHB_W_TOG_ODD 5'h0B
// Field positions
`define CCDHB_LO_LSB 0
`define CCDHB_HI_LSB 16
`define CCDHB_CTRL_CLAMP_POL 0
`define CCDHB_CTRL_PREBLANK_PULSE_POL 1
`define CCDHB_CTRL_MODE_LSB 2
`define CCDHB_CTRL_MASK_A 4
`define CCDHB_CTRL_MASK_B 5
`define CCDHB_CTRL_MASK_L 6
// Write masks and reset values
`define CCDHB_CTRL_MASK 32'h0000007F
`define CCDHB_PAIR_MASK 32'h1FFF1FFF
`define CCDHB_ONE_MASK 32'h00001FFF
`define CCDHB_CTRL_RST 32'h00000003
`define CCDHB_AREA_RST 32'h00001FFF
`define CCDHB_LINE_MAX 13'h1FFF
`define CCDHB_NUM_AREAS 3
`define CCDHB_NUM_TOGS 6

`endif

// [shared/ccdhb_pkg.sv]
package ccdhb_pkg;
   typedef enum logic [1:0] {
      CCDHB_MODE_NORMAL = 2'h0,
      CCDHB_MODE_MIX = 2'h1,
      CCDHB_MODE_ADV = 2'h2,
      CCDHB_MODE_TEST = 2'h3
   } ccdhb_mode_t;

   typedef enum logic [2:0] {
      CCDHB_MIX_IDLE = 3'b001,
      CCDHB_MIX_ON = 3'b010,
      CCDHB_MIX_OFF = 3'b100
   } ccdhb_mix_t;
endpackage

// [design/ccdhb_gen.sv]
`timescale 1ns/1ps
`include "ccdhb_defines.svh"

module ccdhb_gen
   import ccdhb_pkg::*;
#(
   parameter int SEQ_W = 2
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timing generator counters
   input wire logic [12:0] pixel_count,
   input wire logic [12:0] line_count,
   input wire logic [12:0] vertical_sync_lines,
   input wire logic [SEQ_W-1:0] active_seq,
   // Horizontal clocks before blanking
   input wire logic hclk_a_in,
   input wire logic hclk_b_in,
   input wire logic hclk_l_in,
   // Pulses to the sensor and sampling chain
   output logic black_clamp_pulse_n,
   output logic preblank_pulse_n,
   output logic horiz_blank_pulse,
   output logic horiz_clock_phase_one,
   output logic horiz_clock_phase_two,
   output logic horiz_last_stage_clock
);

   localparam int NSEQ = 2 ** SEQ_W;
   localparam int NA = `CCDHB_NUM_AREAS;
   localparam int NT = `CCDHB_NUM_TOGS;

   // Register storage
   logic [31:0] clamp_area_q [NA];
   logic [31:0] preblank_pulse_area_q [NA];
   logic [31:0] seq_q [NSEQ][`CCDHB_SEQ_WORDS];

   // APB decode
   logic acc_seq;
   logic [SEQ_W-1:0] acc_sidx;
   logic [4:0] acc_widx;
   logic acc_hit;
   logic [31:0] rd_val;
   logic [31:0] wr_mask;
   logic wr_en;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [31:0] status_w;

   assign acc_seq = paddr[`CCDHB_SEQ_BASE_BIT];
   assign acc_sidx = paddr[SEQ_W+6:7];
   assign acc_widx = paddr[6:2];

   function automatic logic [31:0] word_mask(input logic [4:0] w);
      if (w == `CCDHB_W_CTRL) begin
         return `CCDHB_CTRL_MASK;
      end else if (w < `CCDHB_W_TOG_EVEN) begin
         return `CCDHB_PAIR_MASK;
      end else begin
         return `CCDHB_ONE_MASK;
      end
   endfunction

   always_comb begin
      acc_hit = 1'b0;
      rd_val = 32'h00000000;
      wr_mask = 32'h00000000;
      if (acc_seq) begin
         if (paddr[10:SEQ_W+7] == '0 && paddr[1:0] == 2'h0
               && acc_widx < 5'(`CCDHB_SEQ_WORDS)) begin
            acc_hit = 1'b1;
            rd_val = seq_q[acc_sidx][acc_widx];
            wr_mask = word_mask(acc_widx);
         end
      end else if (paddr[1:0] == 2'h0) begin
         if (paddr < `CCDHB_PREBLANK_PULSE_AREA0) begin
            acc_hit = 1'b1;
            rd_val = clamp_area_q[paddr[3:2]];
            wr_mask = `CCDHB_PAIR_MASK;
         end else if (paddr < `CCDHB_STATUS) begin
            acc_hit = 1'b1;
            rd_val = preblank_pulse_area_q[2'(paddr[4:2] - 3'h3)];
            wr_mask = `CCDHB_PAIR_MASK;
         end else if (paddr == `CCDHB_STATUS) begin
            acc_hit = 1'b1;
            rd_val = status_w;
         end
      end
   end

   assign pready = pclk_en;
   assign wr_en = psel && penable && pwrite && pclk_en && acc_hit;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   // Read data and error captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (pclk_en && psel && !penable) begin
         prdata_q <= pwrite ? 32'h00000000 : rd_val;
         pslverr_q <= !acc_hit;
      end
   end

   // Global mask areas, power-up value disables them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NA; i++) begin
            clamp_area_q[i] <= `CCDHB_AREA_RST;
            preblank_pulse_area_q[i] <= `CCDHB_AREA_RST;
         end
      end else if (wr_en && !acc_seq) begin
         if (paddr < `CCDHB_PREBLANK_PULSE_AREA0) begin
            clamp_area_q[paddr[3:2]] <= pwdata & wr_mask;
         end else if (paddr < `CCDHB_STATUS) begin
            preblank_pulse_area_q[2'(paddr[4:2] - 3'h3)] <= pwdata & wr_mask;
         end
      end
   end

   // Per-sequence pattern sets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < NSEQ; s++) begin
            for (int w = 0; w < `CCDHB_SEQ_WORDS; w++) begin
               seq_q[s][w] <= (w == 0) ? `CCDHB_CTRL_RST : 32'h00000000;
            end
         end
      end else if (wr_en && acc_seq) begin
         seq_q[acc_sidx][acc_widx] <= pwdata & wr_mask;
      end
   end

   // Active sequence selection
   logic [31:0] ctrl_w;
   logic clamp_pol;
   logic preblank_pulse_pol;
   ccdhb_mode_t mode;
   logic mask_a;
   logic mask_b;
   logic mask_l;
   logic [12:0] clamp_t1, clamp_t2, preblank_pulse_t1, preblank_pulse_t2;
   logic [12:0] blank_start, blank_end, blank_len, blank_rep;

   assign ctrl_w = seq_q[active_seq][`CCDHB_W_CTRL]; // R10
   assign clamp_pol = ctrl_w[`CCDHB_CTRL_CLAMP_POL];
   assign preblank_pulse_pol = ctrl_w[`CCDHB_CTRL_PREBLANK_PULSE_POL];
   assign mode = ccdhb_mode_t'(ctrl_w[`CCDHB_CTRL_MODE_LSB +: 2]); // R13
   assign mask_a = ctrl_w[`CCDHB_CTRL_MASK_A];
   assign mask_b = ctrl_w[`CCDHB_CTRL_MASK_B];
   assign mask_l = ctrl_w[`CCDHB_CTRL_MASK_L];
   assign clamp_t1 = seq_q[active_seq][`CCDHB_W_CLAMP_TOG][12:0];
   assign clamp_t2 = seq_q[active_seq][`CCDHB_W_CLAMP_TOG][28:16];
   assign preblank_pulse_t1 = seq_q[active_seq][`CCDHB_W_PREBLANK_PULSE_TOG][12:0];
   assign preblank_pulse_t2 = seq_q[active_seq][`CCDHB_W_PREBLANK_PULSE_TOG][28:16];
   assign blank_start = seq_q[active_seq][`CCDHB_W_BLANK_SE][12:0]; // R17
   assign blank_end = seq_q[active_seq][`CCDHB_W_BLANK_SE][28:16];
   assign blank_len = seq_q[active_seq][`CCDHB_W_BLANK_LR][12:0]; // R18
   assign blank_rep = seq_q[active_seq][`CCDHB_W_BLANK_LR][28:16];

   // Masking areas, independent of the active sequence
   logic [NA-1:0] clamp_hit;
   logic [NA-1:0] preblank_pulse_hit;
   logic clamp_masked;
   logic preblank_pulse_masked;

   function automatic logic area_hit(input logic [31:0] a,
         input logic [12:0] line, input logic [12:0] vlines);
      logic [12:0] st;
      logic [12:0] en;
      st = a[12:0];
      en = a[28:16];
      return st != `CCDHB_LINE_MAX && st <= vlines // R04
         && line >= st && line <= en; // R21
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < NA; gi++) begin : g_area
         assign clamp_hit[gi] = area_hit(clamp_area_q[gi], line_count,
            vertical_sync_lines); // R01
         assign preblank_pulse_hit[gi] = area_hit(preblank_pulse_area_q[gi], line_count,
            vertical_sync_lines); // R01
      end
   endgenerate

   assign clamp_masked = |clamp_hit; // R02 R03
   assign preblank_pulse_masked = |preblank_pulse_hit; // R02 R03

   // Clamp and preblank patterns, masked lines stay inactive high
   logic clamp_lvl;
   logic preblank_pulse_lvl;
   assign clamp_lvl = clamp_pol ^ (pixel_count >= clamp_t1)
      ^ (pixel_count >= clamp_t2); // R06 R07
   assign preblank_pulse_lvl = preblank_pulse_pol ^ (pixel_count >= preblank_pulse_t1)
      ^ (pixel_count >= preblank_pulse_t2); // R06 R07

   // Six blanking toggles, set picked by line parity
   logic [NT-1:0] tog_bits;
   logic tog_lvl;
   logic [4:0] tog_base;
   assign tog_base = line_count[0] ? `CCDHB_W_TOG_ODD
                                   : `CCDHB_W_TOG_EVEN; // R12
   generate
      for (gi = 0; gi < NT; gi++) begin : g_tog
         assign tog_bits[gi] = pixel_count >=
            seq_q[active_seq][tog_base + 5'(gi)][12:0]; // R11
      end
   endgenerate
   assign tog_lvl = ^tog_bits; // R08

   // Repeated pulse generator for mixing and advanced modes
   ccdhb_mix_t mix_q;
   logic [12:0] mix_cnt_q;
   logic [12:0] mix_left_q;
   logic mix_go;
   logic mix_stop;
   logic mix_on;
   logic blank_win;

   assign mix_go = (mode == CCDHB_MODE_MIX || mode == CCDHB_MODE_ADV)
      && pixel_count == blank_start && blank_len != 13'h0000
      && blank_rep != 13'h0000; // R14 R15
   assign mix_stop = pixel_count == blank_end;
   assign mix_on = mix_q == CCDHB_MIX_ON;
   assign blank_win = pixel_count >= blank_start
      && pixel_count < blank_end; // R15

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mix_q <= CCDHB_MIX_IDLE;
         mix_cnt_q <= 13'h0000;
         mix_left_q <= 13'h0000;
      end else if (pclk_en) begin
         case (mix_q)
            CCDHB_MIX_IDLE: begin
               if (mix_go) begin
                  mix_q <= CCDHB_MIX_ON;
                  mix_cnt_q <= blank_len - 13'h0001; // R18
                  mix_left_q <= blank_rep - 13'h0001;
               end
            end
            CCDHB_MIX_ON: begin
               if (mix_stop) begin
                  mix_q <= CCDHB_MIX_IDLE;
               end else if (mix_cnt_q == 13'h0000) begin
                  mix_q <= CCDHB_MIX_OFF;
                  mix_cnt_q <= blank_len - 13'h0001;
               end else begin
                  mix_cnt_q <= mix_cnt_q - 13'h0001;
               end
            end
            CCDHB_MIX_OFF: begin
               if (mix_stop) begin
                  mix_q <= CCDHB_MIX_IDLE;
               end else if (mix_cnt_q != 13'h0000) begin
                  mix_cnt_q <= mix_cnt_q - 13'h0001;
               end else if (mix_left_q == 13'h0000) begin
                  mix_q <= CCDHB_MIX_IDLE;
               end else begin
                  mix_q <= CCDHB_MIX_ON;
                  mix_cnt_q <= blank_len - 13'h0001;
                  mix_left_q <= mix_left_q - 13'h0001;
               end
            end
            default: begin
               mix_q <= CCDHB_MIX_IDLE;
            end
         endcase
      end
   end

   // Blanking level per mode
   logic blank_d;
   always_comb begin
      case (mode)
         CCDHB_MODE_NORMAL: blank_d = tog_lvl; // R11
         CCDHB_MODE_MIX: blank_d = tog_lvl ^ mix_on; // R14
         CCDHB_MODE_ADV: blank_d = blank_win && !mix_on; // R15
         default: blank_d = 1'b0; // R13
      endcase
   end

   // Output flops
   logic clamp_n_q, preblank_pulse_n_q, blank_q, ph1_q, ph2_q, phl_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clamp_n_q <= 1'b1;
         preblank_pulse_n_q <= 1'b1;
      end else if (pclk_en) begin
         clamp_n_q <= clamp_masked | clamp_lvl; // R01
         preblank_pulse_n_q <= preblank_pulse_masked | preblank_pulse_lvl; // R01
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_q <= 1'b0;
         ph1_q <= 1'b0;
         ph2_q <= 1'b0;
         phl_q <= 1'b0;
      end else if (pclk_en) begin
         blank_q <= blank_d;
         ph1_q <= blank_d ? !mask_a : hclk_a_in; // R09
         ph2_q <= blank_d ? !mask_b : hclk_b_in; // R20
         phl_q <= blank_d ? !mask_l : hclk_l_in; // R20
      end
   end

   assign black_clamp_pulse_n = clamp_n_q;
   assign preblank_pulse_n = preblank_pulse_n_q;
   assign horiz_blank_pulse = blank_q;
   assign horiz_clock_phase_one = ph1_q;
   assign horiz_clock_phase_two = ph2_q;
   assign horiz_last_stage_clock = phl_q;

   assign status_w = {5'h00, blank_q, preblank_pulse_n_q, clamp_n_q, 4'h0,
      4'(active_seq), 3'h0, line_count};

   // Checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_mix_start;
      pclk_en && mix_q == CCDHB_MIX_IDLE && mix_go && !mix_stop;
   endsequence

   sequence s_first_pulse;
      mix_q == CCDHB_MIX_ON && mix_cnt_q == $past(blank_len) - 13'h0001;
   endsequence

   a_clamp_masked_line: assert property ( // R01 R02 R03
      pclk_en && clamp_masked |=> black_clamp_pulse_n)
      else $error("clamp active on a masked line");
   a_preblank_pulse_masked_line: assert property ( // R01 R02
      pclk_en && preblank_pulse_masked |=> preblank_pulse_n)
      else $error("preblank active on a masked line");
   a_area_disabled: assert property ( // R04 R21
      pclk_en && (preblank_pulse_area_q[0][12:0] == `CCDHB_LINE_MAX
      || preblank_pulse_area_q[0][12:0] > vertical_sync_lines
      || preblank_pulse_area_q[0][12:0] > preblank_pulse_area_q[0][28:16])
      |-> !preblank_pulse_hit[0])
      else $error("disabled mask area still hits a line");
   a_clamp_start_pol: assert property ( // R06
      pclk_en && !clamp_masked && pixel_count < clamp_t1
      && pixel_count < clamp_t2 |=> black_clamp_pulse_n == $past(clamp_pol))
      else $error("clamp does not start at its polarity");
   a_clamp_inverted: assert property ( // R07
      pclk_en && !clamp_masked && pixel_count >= clamp_t1
      && pixel_count < clamp_t2 |=> black_clamp_pulse_n != $past(clamp_pol))
      else $error("clamp not inverted after first toggle");
   a_phase_one_force: assert property ( // R09
      pclk_en && blank_d |=> horiz_clock_phase_one == !$past(mask_a))
      else $error("phase one not forced during blanking");
   a_phase_two_pass: assert property ( // R20
      pclk_en && !blank_d |=> horiz_clock_phase_two == $past(hclk_b_in))
      else $error("phase two not passed outside blanking");
   a_normal_toggles: assert property ( // R11 R12
      pclk_en && mode == CCDHB_MODE_NORMAL |=> horiz_blank_pulse
      == $past(^tog_bits))
      else $error("normal blanking does not follow toggles");
   a_test_mode_idle: assert property ( // R13
      pclk_en && mode == CCDHB_MODE_TEST |=> !horiz_blank_pulse)
      else $error("blanking active in test mode");
   a_mix_begins: assert property ( // R14 R18
      s_mix_start |=> s_first_pulse)
      else $error("repeat pulse did not start with its length");
   a_freeze_enable: assert property (
      !pclk_en |=> $stable(horiz_blank_pulse)
      && $stable(black_clamp_pulse_n) && $stable(mix_q))
      else $error("state moved while clock enable low");

endmodule

// [tb/ccdhb_sensor_model.sv]
`timescale 1ns/1ps
module ccdhb_sensor_model (
   // Clock and line restart
   input wire logic pclk,
   input wire logic line_clear,
   // Pulses from the block, both active low
   input wire logic black_clamp_pulse_n,
   input wire logic preblank_pulse_n,
   // Pixels seen under each pulse in the current line
   output logic [15:0] clamp_pixels,
   output logic [15:0] blank_pixels
);
   // The sampling chain acts on the low phase only
   always @(posedge pclk) begin
      if (line_clear) begin
         clamp_pixels <= 16'h0000;
         blank_pixels <= 16'h0000;
      end else begin
         clamp_pixels <= clamp_pixels + 16'(black_clamp_pulse_n === 1'b0);
         blank_pixels <= blank_pixels + 16'(preblank_pulse_n === 1'b0);
      end
   end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rq;
   logic [12:0] pixel_count, line_count, vertical_sync_lines;
   logic [1:0] active_seq;
   logic hclk_a_in, hclk_b_in, hclk_l_in, line_clear, chk_on, rer;
   logic black_clamp_pulse_n, preblank_pulse_n, horiz_blank_pulse;
   logic horiz_clock_phase_one, horiz_clock_phase_two, horiz_last_stage_clock;
   logic [15:0] clamp_pixels, blank_pixels;
   logic [5:0] e;
   int seed, err_total, n_checks, ecl, epb, i, s;
   int ctl[4] = '{3, 3, 3, 3};
   int ct1[4], ct2[4], pt1[4], pt2[4], bst[4], ben[4], blen[4], brep[4];
   int tge[4][6], tgo[4][6], cms[3], cme[3], pms[3], pme[3];
   int lines[9] = '{4, 5, 7, 8, 10, 11, 25, 110, 0};

   ccdhb_gen i_ccdhb_gen (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pixel_count(pixel_count), .line_count(line_count),
      .vertical_sync_lines(vertical_sync_lines), .active_seq(active_seq),
      .hclk_a_in(hclk_a_in), .hclk_b_in(hclk_b_in), .hclk_l_in(hclk_l_in),
      .black_clamp_pulse_n(black_clamp_pulse_n),
      .preblank_pulse_n(preblank_pulse_n),
      .horiz_blank_pulse(horiz_blank_pulse),
      .horiz_clock_phase_one(horiz_clock_phase_one),
      .horiz_clock_phase_two(horiz_clock_phase_two),
      .horiz_last_stage_clock(horiz_last_stage_clock));

   ccdhb_sensor_model i_ccdhb_sensor_model (.pclk(pclk),
      .line_clear(line_clear), .black_clamp_pulse_n(black_clamp_pulse_n),
      .preblank_pulse_n(preblank_pulse_n), .clamp_pixels(clamp_pixels),
      .blank_pixels(blank_pixels));

   always #4 pclk = ~pclk;

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t word got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; entered just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         $display("[FAIL] t=%0t no ready", $time);
         close_out();
      end
      rq = prdata;
      rer = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic acc(input logic w, input logic [11:0] a, input int d,
                      input logic [31:0] x, input logic xe);
      apb(w, a, d);
      if (!w)
         chk_word(rq, x);
      chk_bit(rer, xe);
   endtask

   function automatic int pr(input int lo, input int hi);
      return {3'h0, hi[12:0], 3'h0, lo[12:0]};
   endfunction

   task automatic area(input int k, input int cs, ce, ps, pe);
      cms[k] = cs;
      cme[k] = ce;
      pms[k] = ps;
      pme[k] = pe;
      acc(1'b1, 12'(4 * k), pr(cs, ce), 0, 1'b0);
      acc(1'b1, 12'(12 + 4 * k), pr(ps, pe), 0, 1'b0);
   endtask

   task automatic cfg(input int q, c, a1, a2, b1, b2, bs, be, bl, br, eb);
      logic [11:0] b;
      b = 12'h800 + 12'(q * 128);
      ctl[q] = c;
      ct1[q] = a1;
      ct2[q] = a2;
      pt1[q] = b1;
      pt2[q] = b2;
      bst[q] = bs;
      ben[q] = be;
      blen[q] = bl;
      brep[q] = br;
      apb(1'b1, b, c);
      apb(1'b1, b + 12'h004, pr(a1, a2));
      apb(1'b1, b + 12'h008, pr(b1, b2));
      apb(1'b1, b + 12'h00C, pr(bs, be));
      apb(1'b1, b + 12'h010, pr(bl, br));
      for (int k = 0; k < 6; k++) begin
         tge[q][k] = eb + 7 * k;
         tgo[q][k] = eb + 3 + 5 * k;
         apb(1'b1, b + 12'(20 + 4 * k), tge[q][k]);
         apb(1'b1, b + 12'(44 + 4 * k), tgo[q][k]);
      end
      acc(1'b0, b, 0, 32'(c), 1'b0);
      acc(1'b0, b + 12'h010, 0, 32'(pr(bl, br)), 1'b0);
   endtask

   function automatic logic [5:0] model(int p, int ln, int q, int vs,
                                        logic a, logic b, logic l);
      logic cl, pb, bl, rp;
      int o;
      cl = ctl[q][0] ^ (p >= ct1[q]) ^ (p >= ct2[q]);
      pb = ctl[q][1] ^ (p >= pt1[q]) ^ (p >= pt2[q]);
      for (int k = 0; k < 3; k++) begin
         if (ln >= cms[k] && ln <= cme[k] && cms[k] != 8191 && cms[k] <= vs)
            cl = 1'b1;
         if (ln >= pms[k] && ln <= pme[k] && pms[k] != 8191 && pms[k] <= vs)
            pb = 1'b1;
      end
      bl = 1'b0;
      for (int k = 0; k < 6; k++)
         bl ^= (p >= (ln % 2 ? tgo[q][k] : tge[q][k]));
      // Repeat pulses show from the pixel after the start through the end
      o = p - bst[q] - 1;
      rp = p > bst[q] && p <= ben[q] && blen[q] > 0 &&
           o < 2 * blen[q] * brep[q] && (o / blen[q]) % 2 == 0;
      case (ctl[q][3:2])
         1: bl ^= rp;
         2: bl = p >= bst[q] && p < ben[q] && !rp;
         3: bl = 1'b0;
         default: ;
      endcase
      return {cl, pb, bl, bl ? !ctl[q][4] : a, bl ? !ctl[q][5] : b,
              bl ? !ctl[q][6] : l};
   endfunction

   // Compare with last edge's prediction, then predict the next edge
   always @(posedge pclk) begin
      if (chk_on) begin
         chk_bit(black_clamp_pulse_n, e[5]);
         chk_bit(preblank_pulse_n, e[4]);
         chk_bit(horiz_blank_pulse, e[3]);
         chk_bit(horiz_clock_phase_one, e[2]);
         chk_bit(horiz_clock_phase_two, e[1]);
         chk_bit(horiz_last_stage_clock, e[0]);
      end
      if (line_clear) begin
         ecl = 0;
         epb = 0;
      end else if (chk_on) begin
         ecl += (e[5] == 1'b0);
         epb += (e[4] == 1'b0);
      end
      if (pclk_en)
         e = model(pixel_count, line_count, active_seq, vertical_sync_lines,
                   hclk_a_in, hclk_b_in, hclk_l_in);
   end

   task automatic scan(input int ln, input int q);
      int r;
      line_clear <= 1'b1;
      line_count <= ln[12:0];
      active_seq <= q[1:0];
      pixel_count <= 13'h0000;
      @(posedge pclk);
      line_clear <= 1'b0;
      for (int p = 1; p < 70; p++) begin
         r = $random(seed);
         pixel_count <= p[12:0];
         hclk_a_in <= r[0];
         hclk_b_in <= r[1];
         hclk_l_in <= r[2];
         pclk_en <= 1'b1;
         @(posedge pclk);
         // Occasional frozen cycle with every input held
         if (r[5:3] == 3'h0) begin
            pclk_en <= 1'b0;
            @(posedge pclk);
         end
      end
      pclk_en <= 1'b1;
      @(posedge pclk);
      @(negedge pclk);
      chk_word(32'(clamp_pixels), ecl);
      chk_word(32'(blank_pixels), epb);
      @(posedge pclk);
   endtask

   initial begin
      seed = 32'h8EE6;
      pclk = 1'b0;
      presetn = 1'b0;
      pclk_en = 1'b1;
      {psel, penable, pwrite, line_clear, chk_on} = '0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      {hclk_a_in, hclk_b_in, hclk_l_in} = 3'h0;
      pixel_count = 13'h0000;
      line_count = 13'h0000;
      vertical_sync_lines = 13'h0032;
      active_seq = 2'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      acc(1'b0, 12'h800, 0, 32'h00000003, 1'b0);
      acc(1'b0, 12'h000, 0, 32'h00001FFF, 1'b0);
      acc(1'b0, 12'h018, 0, 32'h03000000, 1'b0);
      acc(1'b0, 12'h844, 0, 32'h00000000, 1'b1);
      acc(1'b1, 12'h01C, 0, 0, 1'b1);
      for (i = 0; i < 3; i++)
         area(i, 8191, 0, 8191, 0);
      // Mode 3 is never written by software
      cfg(1, $random(seed) & 32'h73, 10, 20, 5, 40, 0, 0, 0, 0, 3);
      cfg(2, ($random(seed) & 32'h73) | 32'h4, 15, 8191, 0, 30, 20, 50, 3, 4,
          60);
      cfg(3, ($random(seed) & 32'h73) | 32'h8, 0, 0, 12, 12, 10, 60, 2, 3,
          0);
      area(0, 5, 7, 9, 3);
      area(1, 100, 120, 10, 10);
      area(2, 8191, 8191, 20, 30);
      acc(1'b0, 12'h00C, 0, 32'(pr(9, 3)), 1'b0);
      lines[8] = $random(seed) & 63;
      chk_on <= 1'b1;
      for (i = 0; i < 9; i++)
         for (s = 0; s < 4; s++)
            scan(lines[i], s);
      close_out();
   end
endmodule
